// ==== usb_irq_pkg.sv ====
`default_nettype none
package usb_irq_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS_EN  = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_ERROR      = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_ERROR_EN   = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_CONTROL    = 4'h4;

   // Status flag positions.
   localparam int ST_BUS_RESET = 0;
   localparam int ST_ERROR_SUM = 1;
   localparam int ST_ACTIVITY  = 2;
   localparam int ST_XFER_DONE = 3;
   localparam int ST_IDLE      = 4;
   localparam int ST_STALL     = 5;
   localparam int ST_SOF       = 6;
   localparam logic [DATA_W-1:0] STATUS_MASK = 8'h7F;

   // Control bit positions.
   localparam int CT_MOD_EN  = 0;
   localparam int CT_SUSPEND = 1;
   localparam int CT_PULLUP  = 2;
   localparam logic [DATA_W-1:0] CONTROL_MASK = 8'h07;

   // Reset values.
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

   // Timing.
   localparam int CLK_HZ       = 125_000_000;
   localparam int IDLE_TIME_MS = 3;
   localparam int IDLE_CYCLES  = IDLE_TIME_MS * (CLK_HZ / 1000);
   localparam int SYNC_CYCLES  = 4;
   localparam logic [2:0] SYNC_LOAD = 3'(SYNC_CYCLES);

   typedef enum logic {
      ARM_WAIT_IDLE = 1'b0,
      ARM_READY     = 1'b1
   } arm_state_e;
endpackage
`default_nettype wire

// ==== usb_idle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module usb_idle_timer #(
   parameter int IDLE_CYCLES = usb_irq_pkg::IDLE_CYCLES
) (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rstn,
   // Activity in, idle event out.
   input  wire logic traffic,
   output logic      idle_event
);
   localparam int CW = $clog2(IDLE_CYCLES + 2);
   localparam logic [CW-1:0] LIMIT = CW'(IDLE_CYCLES);
   localparam logic [CW-1:0] DONE  = CW'(IDLE_CYCLES + 1);

   logic [CW-1:0] cnt_r;
   logic          idle_event_r;

   // Counts idle cycles, restarts on traffic, saturates once exceeded.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= '0;
      end else if (traffic) begin
         cnt_r <= '0;
      end else if (cnt_r != DONE) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // One pulse when the idle time is first exceeded.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         idle_event_r <= 1'b0;
      end else begin
         idle_event_r <= !traffic && (cnt_r == LIMIT);
      end
   end

   assign idle_event = idle_event_r;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_idle_after_quiet;
      idle_event |-> $past(cnt_r) == LIMIT && !$past(traffic);
   endproperty
   a_idle_after_quiet: assert property (p_idle_after_quiet)
      else $error("Idle event without full quiet period.");

   property p_restart;
      traffic |=> cnt_r == '0 && !idle_event;
   endproperty
   a_restart: assert property (p_restart)
      else $error("Idle counter not restarted by traffic.");
endmodule
`default_nettype wire

// ==== usb_status_error_irq_logic.sv ====
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module usb_status_error_irq_logic #(
   parameter int IDLE_CYCLES = usb_irq_pkg::IDLE_CYCLES,
   parameter int ERR_W       = usb_irq_pkg::DATA_W
) (
   // Clock and reset.
   input  wire logic                            clock,
   input  wire logic                            rstn,
   // Register port.
   input  wire logic [usb_irq_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [usb_irq_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [usb_irq_pkg::DATA_W-1:0]  reg_rdata,
   // Serial interface engine events.
   input  wire logic                            sie_bus_reset,
   input  wire logic                            sie_transfer_done,
   input  wire logic                            sie_stall,
   input  wire logic                            sie_sof,
   input  wire logic                            sie_token_seen,
   input  wire logic [ERR_W-1:0]                sie_errors,
   // Bus line activity from the pins.
   input  wire logic                            line_activity,
   // Outputs.
   output logic                                 cpu_usb_irq_request,
   output logic                                 module_enable_out,
   output logic                                 suspend_out,
   output logic                                 pullup_enable_out
);
   localparam int DW = usb_irq_pkg::DATA_W;

   logic [DW-1:0]    status_r;
   logic [DW-1:0]    status_nxt;
   logic [DW-1:0]    status_en_r;
   logic [ERR_W-1:0] error_r;
   logic [ERR_W-1:0] error_nxt;
   logic [ERR_W-1:0] error_en_r;
   logic [DW-1:0]    control_r;
   logic [DW-1:0]    rdata_r;
   logic             irq_r;
   logic             line_meta_r;
   logic             line_sync_r;
   logic             traffic;
   logic             idle_event;
   logic             act_set;
   logic             clear_block;
   logic             err_summary;
   logic [2:0]       sync_cnt_r;
   logic             wr_status;
   logic             wr_error;
   usb_irq_pkg::arm_state_e arm_r;

   // The address is an argument so that every caller is sensitive to it.
   function automatic logic hit(input logic [usb_irq_pkg::ADDR_W-1:0] addr,
                                input logic [usb_irq_pkg::ADDR_W-1:0] ofs);
      hit = addr == ofs;
   endfunction

   assign wr_status = reg_wr && hit(reg_addr, usb_irq_pkg::OFS_STATUS);
   assign wr_error  = reg_wr && hit(reg_addr, usb_irq_pkg::OFS_ERROR);

   // Two-stage synchroniser for the asynchronous line activity.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         line_meta_r <= 1'b0;
         line_sync_r <= 1'b0;
      end else begin
         line_meta_r <= line_activity;
         line_sync_r <= line_meta_r;
      end
   end

   assign traffic = sie_token_seen || line_sync_r;

   usb_idle_timer #(
      .IDLE_CYCLES (IDLE_CYCLES)
   ) u_idle (
      .clock      (clock),
      .rstn       (rstn),
      .traffic    (traffic),
      .idle_event (idle_event)
   );

   // Activity re-arm: armed by an idle event, disarmed by the activity set.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         arm_r <= usb_irq_pkg::ARM_WAIT_IDLE;
      end else begin
         unique case (arm_r)
            usb_irq_pkg::ARM_WAIT_IDLE: begin
               if (idle_event) begin
                  arm_r <= usb_irq_pkg::ARM_READY;
               end
            end
            usb_irq_pkg::ARM_READY: begin
               if (traffic) begin
                  arm_r <= usb_irq_pkg::ARM_WAIT_IDLE;
               end
            end
         endcase
      end
   end

   assign act_set = (arm_r == usb_irq_pkg::ARM_READY) && traffic;

   // Wake synchronisation window after the suspend bit falls.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync_cnt_r <= 3'h0;
      end else if (control_r[usb_irq_pkg::CT_SUSPEND]) begin
         sync_cnt_r <= usb_irq_pkg::SYNC_LOAD;
      end else if (sync_cnt_r != 3'h0) begin
         sync_cnt_r <= sync_cnt_r - 3'h1;
      end
   end

   assign clear_block = control_r[usb_irq_pkg::CT_SUSPEND]
                        || (sync_cnt_r != 3'h0);

   assign err_summary = |(error_r & error_en_r);

   // Status flags: write stores the value except a clear of activity while suspended or in the wake window, hardware sets win over clears.
   always_comb begin
      status_nxt = status_r;
      if (wr_status) begin
         status_nxt = reg_wdata & usb_irq_pkg::STATUS_MASK;
         if (clear_block) begin
            status_nxt[usb_irq_pkg::ST_ACTIVITY] =
               status_r[usb_irq_pkg::ST_ACTIVITY]
               | reg_wdata[usb_irq_pkg::ST_ACTIVITY];
         end
      end
      // Flags set regardless of the status enables.
      if (sie_bus_reset) begin
         status_nxt[usb_irq_pkg::ST_BUS_RESET] = 1'b1;
      end
      if (err_summary) begin
         status_nxt[usb_irq_pkg::ST_ERROR_SUM] = 1'b1;
      end
      if (act_set) begin
         status_nxt[usb_irq_pkg::ST_ACTIVITY] = 1'b1;
      end
      if (sie_transfer_done) begin
         status_nxt[usb_irq_pkg::ST_XFER_DONE] = 1'b1;
      end
      if (idle_event) begin
         status_nxt[usb_irq_pkg::ST_IDLE] = 1'b1;
      end
      if (sie_stall) begin
         status_nxt[usb_irq_pkg::ST_STALL] = 1'b1;
      end
      if (sie_sof) begin
         status_nxt[usb_irq_pkg::ST_SOF] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         status_r <= usb_irq_pkg::REG_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Error flags set in the cycle of detection, kept until software clears.
   always_comb begin
      error_nxt = error_r;
      if (wr_error) begin
         error_nxt = reg_wdata[ERR_W-1:0];
      end
      error_nxt = error_nxt | sie_errors;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         error_r <= ERR_W'(usb_irq_pkg::REG_RESET);
      end else begin
         error_r <= error_nxt;
      end
   end

   // Enable and control registers.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         status_en_r <= usb_irq_pkg::REG_RESET;
         error_en_r  <= ERR_W'(usb_irq_pkg::REG_RESET);
         control_r   <= usb_irq_pkg::REG_RESET;
      end else if (reg_wr) begin
         if (hit(reg_addr, usb_irq_pkg::OFS_STATUS_EN)) begin
            status_en_r <= reg_wdata & usb_irq_pkg::STATUS_MASK;
         end
         if (hit(reg_addr, usb_irq_pkg::OFS_ERROR_EN)) begin
            error_en_r <= reg_wdata[ERR_W-1:0];
         end
         if (hit(reg_addr, usb_irq_pkg::OFS_CONTROL)) begin
            control_r <= reg_wdata & usb_irq_pkg::CONTROL_MASK;
         end
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= usb_irq_pkg::REG_RESET;
      end else if (reg_rd) begin
         unique case (reg_addr)
            usb_irq_pkg::OFS_STATUS:    rdata_r <= status_r;
            usb_irq_pkg::OFS_STATUS_EN: rdata_r <= status_en_r;
            usb_irq_pkg::OFS_ERROR:     rdata_r <= DW'(error_r);
            usb_irq_pkg::OFS_ERROR_EN:  rdata_r <= DW'(error_en_r);
            usb_irq_pkg::OFS_CONTROL:   rdata_r <= control_r;
            default:                    rdata_r <= usb_irq_pkg::REG_RESET;
         endcase
      end else begin
         rdata_r <= usb_irq_pkg::REG_RESET;
      end
   end

   // Single CPU interrupt from all enabled status flags.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_r & status_en_r);
      end
   end

   assign reg_rdata           = rdata_r;
   assign cpu_usb_irq_request = irq_r;
   assign module_enable_out   = control_r[usb_irq_pkg::CT_MOD_EN];
   assign suspend_out         = control_r[usb_irq_pkg::CT_SUSPEND];
   // The pull-up ignores the suspend bit.
   assign pullup_enable_out   = control_r[usb_irq_pkg::CT_PULLUP]
                                && control_r[usb_irq_pkg::CT_MOD_EN];

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_blocked_clear;
      wr_status && clear_block
      && status_r[usb_irq_pkg::ST_ACTIVITY]
      && !reg_wdata[usb_irq_pkg::ST_ACTIVITY];
   endsequence

   sequence s_activity_then_quiet;
      act_set ##1 !idle_event;
   endsequence

   property p_clear_ignored;
      s_blocked_clear |=> status_r[usb_irq_pkg::ST_ACTIVITY];
   endproperty
   a_clear_ignored: assert property (p_clear_ignored)
      else $error("Activity flag cleared inside the sync window.");

   property p_wake_window;
      $fell(control_r[usb_irq_pkg::CT_SUSPEND]) |-> clear_block [*4]
         ##1 !clear_block;
   endproperty
   a_wake_window: assert property (p_wake_window)
      else $error("Wake sync window has the wrong length.");

   property p_activity_once;
      s_activity_then_quiet |-> !act_set;
   endproperty
   a_activity_once: assert property (p_activity_once)
      else $error("Activity set again without an idle event.");

   property p_sof_unmasked;
      sie_sof |=> status_r[usb_irq_pkg::ST_SOF];
   endproperty
   a_sof_unmasked: assert property (p_sof_unmasked)
      else $error("Start-of-frame flag not set.");

   property p_err_summary;
      |(error_r & error_en_r) |=> status_r[usb_irq_pkg::ST_ERROR_SUM];
   endproperty
   a_err_summary: assert property (p_err_summary)
      else $error("Error summary flag not set by an enabled error.");

   property p_err_immediate;
      sie_errors != '0 |=> (error_r & $past(sie_errors)) == $past(sie_errors);
   endproperty
   a_err_immediate: assert property (p_err_immediate)
      else $error("Error flag not set in the detection cycle.");

   property p_status_sticky;
      !wr_status |=> (status_r & $past(status_r)) == $past(status_r);
   endproperty
   a_status_sticky: assert property (p_status_sticky)
      else $error("Status flag cleared without a software write.");

   property p_error_sticky;
      !wr_error |=> (error_r & $past(error_r)) == $past(error_r);
   endproperty
   a_error_sticky: assert property (p_error_sticky)
      else $error("Error flag cleared without a software write.");

   property p_idle_flag;
      idle_event |=> status_r[usb_irq_pkg::ST_IDLE];
   endproperty
   a_idle_flag: assert property (p_idle_flag)
      else $error("Idle flag not set by the idle event.");

   property p_pullup_suspend;
      control_r[usb_irq_pkg::CT_SUSPEND] && control_r[usb_irq_pkg::CT_PULLUP]
      && control_r[usb_irq_pkg::CT_MOD_EN] |-> pullup_enable_out;
   endproperty
   a_pullup_suspend: assert property (p_pullup_suspend)
      else $error("Pull-up released during suspend.");

   property p_irq_funnel;
      ##1 cpu_usb_irq_request == $past(|(status_r & status_en_r));
   endproperty
   a_irq_funnel: assert property (p_irq_funnel)
      else $error("Interrupt does not follow enabled status flags.");

   property p_sw_set;
      wr_status |=> (status_r | ~($past(reg_wdata)
                     & usb_irq_pkg::STATUS_MASK)) == '1;
   endproperty
   a_sw_set: assert property (p_sw_set)
      else $error("Software write failed to set a status flag.");

   property p_sum_needs_error;
      !wr_status && !err_summary && !status_r[usb_irq_pkg::ST_ERROR_SUM]
      |=> !status_r[usb_irq_pkg::ST_ERROR_SUM];
   endproperty
   a_sum_needs_error: assert property (p_sum_needs_error)
      else $error("Error summary set without an enabled error flag.");

   property p_idle_needs_event;
      !wr_status && !idle_event && !status_r[usb_irq_pkg::ST_IDLE]
      |=> !status_r[usb_irq_pkg::ST_IDLE];
   endproperty
   a_idle_needs_event: assert property (p_idle_needs_event)
      else $error("Idle flag set without an idle event.");

   property p_act_needs_arm;
      !wr_status && !act_set && !status_r[usb_irq_pkg::ST_ACTIVITY]
      |=> !status_r[usb_irq_pkg::ST_ACTIVITY];
   endproperty
   a_act_needs_arm: assert property (p_act_needs_arm)
      else $error("Activity flag set while not armed by idle.");

   property p_xfer_unmasked;
      sie_transfer_done |=> status_r[usb_irq_pkg::ST_XFER_DONE];
   endproperty
   a_xfer_unmasked: assert property (p_xfer_unmasked)
      else $error("Transfer done flag not set.");
endmodule
`default_nettype wire

// ==== usb_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far side of the block: bus traffic and engine events as the host sees them.
module usb_bus_model (
   // Clock.
   input  wire logic       clock,
   // Engine events.
   output logic            bus_reset,
   output logic            xfer_done,
   output logic            stall,
   output logic            sof,
   output logic            token,
   output logic [7:0]      errors,
   // Line level.
   output logic            line_act
);
   initial begin
      {sof, stall, xfer_done, bus_reset, token} = 5'h00;
      errors = 8'h00;
      line_act = 1'b1;
   end

   // One cycle of events, error detects and token traffic.
   task automatic pulse(input logic [3:0] ev, input logic [7:0] err,
                        input logic tok);
      @(posedge clock);
      {sof, stall, xfer_done, bus_reset} <= ev;
      errors <= err;
      token <= tok;
      @(posedge clock);
      {sof, stall, xfer_done, bus_reset, token} <= 5'h00;
      errors <= 8'h00;
   endtask

   // Stopping all line traffic is how the host asks for suspend.
   task automatic set_line(input logic v);
      @(posedge clock);
      line_act <= v;
   endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int IDLE_N = 20;
   localparam logic [3:0] A_ST = usb_irq_pkg::OFS_STATUS;
   localparam logic [3:0] A_SE = usb_irq_pkg::OFS_STATUS_EN;
   localparam logic [3:0] A_ER = usb_irq_pkg::OFS_ERROR;
   localparam logic [3:0] A_EE = usb_irq_pkg::OFS_ERROR_EN;
   localparam logic [3:0] A_CT = usb_irq_pkg::OFS_CONTROL;
   localparam logic [7:0] B_ACT = 8'(1 << usb_irq_pkg::ST_ACTIVITY);
   localparam logic [7:0] B_IDL = 8'(1 << usb_irq_pkg::ST_IDLE);
   localparam logic [7:0] B_SUM = 8'(1 << usb_irq_pkg::ST_ERROR_SUM);
   logic [7:0] ev_bit [4];
   logic       clock, rstn, reg_wr, reg_rd;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, errs, got;
   logic       brst, xdone, stl, sof, tok, line, irq, mod_en, susp, pull;
   int         error_cnt, n_checks, cyc, tries;

   usb_bus_model host (.clock(clock), .bus_reset(brst), .xfer_done(xdone),
      .stall(stl), .sof(sof), .token(tok), .errors(errs), .line_act(line));

   usb_status_error_irq_logic #(.IDLE_CYCLES(IDLE_N)) DUT (
      .clock(clock), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sie_bus_reset(brst),
      .sie_transfer_done(xdone), .sie_stall(stl), .sie_sof(sof),
      .sie_token_seen(tok), .sie_errors(errs), .line_activity(line),
      .cpu_usb_irq_request(irq), .module_enable_out(mod_en),
      .suspend_out(susp), .pullup_enable_out(pull));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         finish_test;
      end
   end

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] g);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 g = reg_rdata;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] g;
      rd(a, g);
      chk8(g, e);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   initial begin
      ev_bit = '{8'(1 << usb_irq_pkg::ST_BUS_RESET),
                 8'(1 << usb_irq_pkg::ST_XFER_DONE),
                 8'(1 << usb_irq_pkg::ST_STALL),
                 8'(1 << usb_irq_pkg::ST_SOF)};
      {rstn, reg_wr, reg_rd} = 3'h0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      {error_cnt, n_checks, cyc} = 0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      for (int a = 0; a < 5; a++)
         rdc(4'(a), 8'h00);
      wr(4'h7, 8'hff);
      rdc(4'h7, 8'h00);
      chk1(irq, 1'b0);
      chk1(mod_en, 1'b0);
      chk1(pull, 1'b0);
      $display("test reset done");

      for (int i = 0; i < 4; i++) begin
         host.pulse(4'(1 << i), 8'h00, 1'b0);
         wait_n(4);
         rdc(A_ST, ev_bit[i]);
         chk1(irq, 1'b0);
         wr(A_SE, ev_bit[i]);
         wait_n(2);
         chk1(irq, 1'b1);
         wr(A_ST, 8'h00);
         wait_n(2);
         chk1(irq, 1'b0);
         wr(A_SE, 8'h00);
      end
      wr(A_ST, 8'h20);
      wr(A_SE, 8'h20);
      wait_n(2);
      chk1(irq, 1'b1);
      rdc(A_ST, 8'h20);
      wr(A_ST, 8'h00);
      wr(A_SE, 8'h00);
      $display("test status done");

      host.pulse(4'h0, 8'h81, 1'b0);
      rdc(A_ER, 8'h81);
      rdc(A_ST, 8'h00);
      wr(A_EE, 8'h01);
      wait_n(3);
      rdc(A_ST, B_SUM);
      wr(A_SE, B_SUM);
      wait_n(2);
      chk1(irq, 1'b1);
      wr(A_ER, 8'h00);
      wr(A_ST, 8'h00);
      wait_n(3);
      rdc(A_ST, 8'h00);
      chk1(irq, 1'b0);
      wr(A_SE, 8'h00);
      wr(A_EE, 8'h00);
      $display("test error done");

      host.set_line(1'b0);
      wait_n(15);
      rdc(A_ST, 8'h00);
      wait_n(10);
      rdc(A_ST, B_IDL);
      wr(A_ST, 8'h00);
      host.pulse(4'h0, 8'h00, 1'b1);
      rdc(A_ST, B_ACT);
      wr(A_ST, 8'h00);
      host.pulse(4'h0, 8'h00, 1'b1);
      host.pulse(4'h0, 8'h00, 1'b1);
      rdc(A_ST, 8'h00);
      wait_n(25);
      rdc(A_ST, B_IDL);
      wr(A_CT, 8'h03);
      host.pulse(4'h0, 8'h00, 1'b1);
      chk1(susp, 1'b1);
      rdc(A_ST, B_IDL | B_ACT);
      wr(A_ST, 8'h00);
      rdc(A_ST, B_ACT);
      host.pulse(4'h0, 8'h00, 1'b1);
      wr(A_CT, 8'h01);
      tries = 0;
      got = B_ACT;
      while (got[2] !== 1'b0 && tries < 8) begin
         wr(A_ST, 8'h00);
         rd(A_ST, got);
         tries++;
      end
      chk8(got, 8'h00);
      chk1(tries > 1, 1'b1);
      $display("test activity done");

      wr(A_CT, 8'h07);
      wait_n(2);
      chk1(pull, 1'b1);
      chk1(susp, 1'b1);
      chk1(mod_en, 1'b1);
      wr(A_CT, 8'h04);
      wait_n(2);
      chk1(pull, 1'b0);
      chk1(mod_en, 1'b0);
      $display("test control done");

      @(posedge clock);
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      for (int a = 0; a < 5; a++)
         rdc(4'(a), 8'h00);
      chk1(irq, 1'b0);
      chk1(pull, 1'b0);
      $display("test reset again done");
      finish_test;
   end
endmodule
`default_nettype wire
